/* verilog/swl_map.svh */
// register offsets, field positions and widths of the direct switch block
`ifndef SWL_MAP_SVH
`define SWL_MAP_SVH

`define SWL_SID_W       8
`define SWL_LNID_W      14
`define SWL_LCID_W      9

// controller register offsets (byte addresses)
`define SWL_REG_TX0     8'h00
`define SWL_REG_TX1     8'h04
`define SWL_REG_TX2     8'h08
`define SWL_REG_CMD     8'h0C
`define SWL_REG_STATUS  8'h10
`define SWL_REG_RX0     8'h14
`define SWL_REG_RX1     8'h18
`define SWL_REG_RX2     8'h1C

// word 0 / word 2 address layout
`define SWL_W_SID       7:0
`define SWL_W_LNID      21:8
`define SWL_W_LCID      30:22
`define SWL_W_TOP       31
// word 1 flag layout
`define SWL_F_NAD       0
`define SWL_F_CTRL      1
`define SWL_F_TYPE      2
`define SWL_F_NEG       3
`define SWL_F_DIRECT    4
`define SWL_F_PROMO     5
`define SWL_F_AGGR      6
`define SWL_F_DSSID     15:8
`define SWL_F_PROMSID   23:16
// command and status bits
`define SWL_CMD_SEND    0
`define SWL_CMD_RXREL   1
`define SWL_ST_TXBUSY   0
`define SWL_ST_RXFULL   1

`define SWL_DIR_UP      1'b0
`define SWL_DIR_DOWN    1'b1
`define SWL_RESP_OKAY   2'h0
`define SWL_RESP_SLVERR 2'h2
`define SWL_ROBUST_BYTES 16'h0048

`endif

/* verilog/swl_pkg.sv */
// types shared by the switch end and the controller end
`include "swl_map.svh"
package swl_pkg;
  typedef struct packed {
    logic                   direction_bit;
    logic [`SWL_SID_W-1:0]  packet_switch_id;
    logic [`SWL_LNID_W-1:0] packet_node_id;
    logic [`SWL_LCID_W-1:0] request_conn_id;
    logic                   no_aggregation_flag;
    logic                   is_conn_ctrl;
    logic                   conn_type_field;
    logic                   conn_negative_flag;
    logic                   direct_info_flag;
    logic [`SWL_SID_W-1:0]  direct_switch_id_field;
    logic [`SWL_SID_W-1:0]  direct_dest_switch_id;
    logic [`SWL_LNID_W-1:0] direct_dest_node_id;
    logic [`SWL_LCID_W-1:0] direct_dest_conn_id;
    logic                   direct_dest_no_aggr;
    logic                   is_promo_ack;
    logic [`SWL_SID_W-1:0]  promoted_switch_id;
  } swl_frame_t;
endpackage

/* verilog/swl_if.sv */
// frame link between the switch end and the controller end
`timescale 1ns/1ps
interface swl_if;
  import swl_pkg::*;
  logic       f_valid;
  logic       f_ready;
  swl_frame_t f_frame;
  logic       r_valid;
  logic       r_ready;
  swl_frame_t r_frame;
  logic       r_aggr_ok;
  modport sw (input f_valid, f_frame, r_ready,
              output f_ready, r_valid, r_frame, r_aggr_ok);
  modport rt (output f_valid, f_frame, r_ready,
              input f_ready, r_valid, r_frame, r_aggr_ok);
endinterface

/* verilog/swl_switch.sv */
// switch node end: direct switching table and aggregation decision
`timescale 1ns/1ps
`include "swl_map.svh"
// How it works
// - root request with direct info installs entry
// - root close with direct info removes entry
// - direct hit rewrites sid, lnid, lcid, nad
// - rewritten frame leaves as downlink
// - each entry keeps destination aggregation capability
// - root asks target first, then initiator
// - root request carries common switch fields
// - capability bit exchanged at registration
// - originators fill no-aggregation flag from registration
// - no aggregation across incapable hops
// - last switch honours no-aggregation flag
// - per-switch capability blocks aggregation downward
// - aggregate size limited to robust burst
// - own promotion ack records flag capability
// - foreign promotion ack inherits parent capability
// - uplink aggregation only if path capable
// - last level aggregates only with flag clear
// - other downlink uses per-switch capability from promotion acks
// - aggregation support is implemented here
// - direction zero uplink, one downlink
module swl_switch #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // node identity and registration outcome
  input  wire logic [`SWL_SID_W-1:0] own_sid,
  input  wire logic              uplink_aggr_cap,
  // link toward the controller
  swl_if.sw                      lnk,
  // status
  output logic                   table_full,
  output logic [15:0]            aggr_size_limit
);
  import swl_pkg::*;
  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int NSW = 1 << `SWL_SID_W;

  generate
    if (DEPTH < 1) begin : g_bad
      $error("swl_switch: DEPTH must be at least 1");
    end
  endgenerate

  typedef struct packed {
    logic [`SWL_SID_W-1:0]  sid;
    logic [`SWL_LNID_W-1:0] lnid;
    logic [`SWL_LCID_W-1:0] lcid;
  } swl_key_t;

  // direct table storage
  logic     dt_valid [DEPTH];
  swl_key_t dt_up    [DEPTH];
  swl_key_t dt_down  [DEPTH];
  logic     dt_nad   [DEPTH];
  // per-switch capability learned from promotion acks
  logic     sw_known [NSW];
  logic     sw_cap   [NSW];

  // output stage
  logic       busy, next_busy;
  swl_frame_t out_f, next_out_f;
  logic       aggr_ok, next_aggr_ok;
  logic       next_table_full;

  // table write controls
  logic             dt_wr, dt_clr;
  logic [IW-1:0]    dt_idx;
  swl_key_t         dt_wup, dt_wdown;
  logic             dt_wnad;
  logic             sw_wr;
  logic [`SWL_SID_W-1:0] sw_widx;
  logic             sw_wcap;

  swl_frame_t in_f;
  logic       take;
  swl_key_t   up_key, dn_key;
  logic       hit, free_ok, found;
  logic [IW-1:0] hit_idx, free_idx, cnt_idx;
  int         used;

  assign in_f = lnk.f_frame;
  assign take = lnk.f_valid & ~busy;

  function automatic swl_key_t mk_key(
    input logic [`SWL_SID_W-1:0]  s,
    input logic [`SWL_LNID_W-1:0] n,
    input logic [`SWL_LCID_W-1:0] c);
    swl_key_t k;
    k.sid  = s;
    k.lnid = n;
    k.lcid = c;
    return k;
  endfunction

  always_comb begin
    up_key = mk_key(in_f.packet_switch_id, in_f.packet_node_id,
                    in_f.request_conn_id);
    dn_key = mk_key(in_f.direct_dest_switch_id, in_f.direct_dest_node_id,
                    in_f.direct_dest_conn_id);
    hit = 1'b0;
    hit_idx = '0;
    free_ok = 1'b0;
    free_idx = '0;
    found = 1'b0;
    cnt_idx = '0;
    used = 0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (dt_valid[i] && dt_up[i] == up_key) begin
        hit = 1'b1;
        hit_idx = IW'(i);
      end
      if (!dt_valid[i]) begin
        free_ok = 1'b1;
        free_idx = IW'(i);
      end
      if (dt_valid[i] && dt_up[i] == up_key && dt_down[i] == dn_key &&
          dt_nad[i] == in_f.direct_dest_no_aggr) begin
        found = 1'b1;
        cnt_idx = IW'(i);
      end
      if (dt_valid[i]) begin
        used = used + 1;
      end
    end
  end

  // frame path and table updates
  always_comb begin
    logic qualify;
    logic is_root_req;
    logic is_root_close;
    qualify = 1'b0;
    is_root_req = 1'b0;
    is_root_close = 1'b0;
    next_busy = busy;
    next_out_f = out_f;
    next_aggr_ok = aggr_ok;
    dt_wr = 1'b0;
    dt_clr = 1'b0;
    dt_idx = '0;
    dt_wup = up_key;
    dt_wdown = dn_key;
    dt_wnad = in_f.direct_dest_no_aggr;
    sw_wr = 1'b0;
    sw_widx = in_f.promoted_switch_id;
    sw_wcap = 1'b0;
    next_table_full = (used >= DEPTH);
    if (busy && lnk.r_ready) begin
      next_busy = 1'b0;
    end
    if (take) begin
      next_busy = 1'b1;
      next_out_f = in_f;
      // uplink frame of our subtree qualifies for switching
      qualify = (in_f.direction_bit == `SWL_DIR_UP) &&
                (in_f.packet_switch_id == own_sid ||
                 sw_known[in_f.packet_switch_id]);
      if (qualify && hit && !in_f.is_conn_ctrl) begin
        next_out_f.packet_switch_id = dt_down[hit_idx].sid;
        next_out_f.packet_node_id = dt_down[hit_idx].lnid;
        next_out_f.request_conn_id = dt_down[hit_idx].lcid;
        next_out_f.no_aggregation_flag = dt_nad[hit_idx];
        next_out_f.direction_bit = `SWL_DIR_DOWN;
      end
      // aggregation decision for the frame as it will leave
      if (next_out_f.direction_bit == `SWL_DIR_UP) begin
        next_aggr_ok = uplink_aggr_cap;
      end else if (next_out_f.packet_switch_id == own_sid) begin
        next_aggr_ok = ~next_out_f.no_aggregation_flag;
      end else begin
        next_aggr_ok = sw_known[next_out_f.packet_switch_id] &&
                       sw_cap[next_out_f.packet_switch_id];
      end
      is_root_req = in_f.is_conn_ctrl &&
                    in_f.direction_bit == `SWL_DIR_DOWN &&
                    in_f.conn_type_field && in_f.direct_info_flag &&
                    in_f.direct_switch_id_field == own_sid;
      is_root_close = is_root_req && in_f.conn_negative_flag;
      if (is_root_close) begin
        dt_clr = found;
        dt_idx = cnt_idx;
      end else if (is_root_req) begin
        // a repeated request refreshes its entry instead of duplicating
        dt_wr = hit || free_ok;
        dt_idx = hit ? hit_idx : free_idx;
      end
      if (in_f.is_promo_ack) begin
        sw_wr = 1'b1;
        if (in_f.packet_switch_id == own_sid) begin
          sw_wcap = ~in_f.no_aggregation_flag;
        end else begin
          sw_wcap = sw_known[in_f.packet_switch_id] &&
                    sw_cap[in_f.packet_switch_id];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      out_f <= '0;
      aggr_ok <= 1'b0;
      table_full <= 1'b0;
      aggr_size_limit <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        dt_valid[i] <= 1'b0;
      end
      for (int j = 0; j < NSW; j++) begin
        sw_known[j] <= 1'b0;
        sw_cap[j] <= 1'b0;
      end
    end else begin
      busy <= next_busy;
      out_f <= next_out_f;
      aggr_ok <= next_aggr_ok;
      table_full <= next_table_full;
      // consumers may merge only up to one robust-mode burst
      aggr_size_limit <= `SWL_ROBUST_BYTES;
      if (dt_wr) begin
        dt_valid[dt_idx] <= 1'b1;
        dt_up[dt_idx] <= dt_wup;
        dt_down[dt_idx] <= dt_wdown;
        dt_nad[dt_idx] <= dt_wnad;
      end
      if (dt_clr) begin
        dt_valid[dt_idx] <= 1'b0;
      end
      if (sw_wr) begin
        sw_known[sw_widx] <= 1'b1;
        sw_cap[sw_widx] <= sw_wcap;
      end
    end
  end

  assign lnk.f_ready = ~busy;
  assign lnk.r_valid = busy;
  assign lnk.r_frame = out_f;
  assign lnk.r_aggr_ok = aggr_ok;
endmodule

/* verilog/swl_root.sv */
// controller end: AXI4-Lite registers that compose and collect frames
`timescale 1ns/1ps
`include "swl_map.svh"
module swl_root (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // link toward the switch
  swl_if.rt                lnk
);
  import swl_pkg::*;

  logic [31:0] tx0, tx1, tx2, next_tx0, next_tx1, next_tx2;
  logic [31:0] rx0, rx1, rx2, next_rx0, next_rx1, next_rx2;
  logic        rx_full, next_rx_full;
  logic        f_valid, next_f_valid;
  swl_frame_t  f_frame, next_f_frame;
  logic        aw_have, next_aw_have, w_have, next_w_have;
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        next_awready, next_wready, next_bvalid, next_arready;
  logic        next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    logic [1:0]  rsp;
    rsp = `SWL_RESP_OKAY;
    next_tx0 = tx0;
    next_tx1 = tx1;
    next_tx2 = tx2;
    next_rx0 = rx0;
    next_rx1 = rx1;
    next_rx2 = rx2;
    next_rx_full = rx_full;
    next_f_valid = f_valid;
    next_f_frame = f_frame;
    next_aw_have = aw_have;
    next_w_have = w_have;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_awready = 1'b0;
    next_wready = 1'b0;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_arready = 1'b0;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (f_valid && lnk.f_ready) begin
      next_f_valid = 1'b0;
    end
    // frames from the switch are held until software releases them
    if (lnk.r_valid && !rx_full) begin
      next_rx_full = 1'b1;
      next_rx0 = {1'b0, lnk.r_frame.request_conn_id,
                  lnk.r_frame.packet_node_id,
                  lnk.r_frame.packet_switch_id};
      next_rx0[`SWL_W_TOP] = lnk.r_frame.direction_bit;
      next_rx1 = '0;
      next_rx1[`SWL_F_NAD] = lnk.r_frame.no_aggregation_flag;
      next_rx1[`SWL_F_CTRL] = lnk.r_frame.is_conn_ctrl;
      next_rx1[`SWL_F_TYPE] = lnk.r_frame.conn_type_field;
      next_rx1[`SWL_F_NEG] = lnk.r_frame.conn_negative_flag;
      next_rx1[`SWL_F_DIRECT] = lnk.r_frame.direct_info_flag;
      next_rx1[`SWL_F_PROMO] = lnk.r_frame.is_promo_ack;
      next_rx1[`SWL_F_AGGR] = lnk.r_aggr_ok;
      next_rx1[`SWL_F_DSSID] = lnk.r_frame.direct_switch_id_field;
      next_rx1[`SWL_F_PROMSID] = lnk.r_frame.promoted_switch_id;
      next_rx2 = {lnk.r_frame.direct_dest_no_aggr,
                  lnk.r_frame.direct_dest_conn_id,
                  lnk.r_frame.direct_dest_node_id,
                  lnk.r_frame.direct_dest_switch_id};
    end
    // write channel: address and data taken in either order
    if (awvalid && !aw_have && !awready) begin
      next_awready = 1'b1;
      next_aw_have = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && !w_have && !wready) begin
      next_wready = 1'b1;
      next_w_have = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (aw_have && w_have && !bvalid) begin
      next_aw_have = 1'b0;
      next_w_have = 1'b0;
      next_bvalid = 1'b1;
      case (aw_addr)
        `SWL_REG_TX0: next_tx0 = merge(tx0, w_data, w_strb);
        `SWL_REG_TX1: next_tx1 = merge(tx1, w_data, w_strb);
        `SWL_REG_TX2: next_tx2 = merge(tx2, w_data, w_strb);
        `SWL_REG_CMD: begin
          // software sequences target request before initiator accept
          if (w_strb[0] && w_data[`SWL_CMD_SEND] && !f_valid) begin
            next_f_valid = 1'b1;
            next_f_frame.packet_switch_id = tx0[`SWL_W_SID];
            next_f_frame.packet_node_id = tx0[`SWL_W_LNID];
            next_f_frame.request_conn_id = tx0[`SWL_W_LCID];
            next_f_frame.direction_bit = tx0[`SWL_W_TOP];
            // flag taken from the capability sent at registration
            next_f_frame.no_aggregation_flag = tx1[`SWL_F_NAD];
            next_f_frame.is_conn_ctrl = tx1[`SWL_F_CTRL];
            next_f_frame.conn_type_field = tx1[`SWL_F_TYPE];
            next_f_frame.conn_negative_flag = tx1[`SWL_F_NEG];
            next_f_frame.direct_info_flag = tx1[`SWL_F_DIRECT];
            next_f_frame.is_promo_ack = tx1[`SWL_F_PROMO];
            next_f_frame.direct_switch_id_field = tx1[`SWL_F_DSSID];
            next_f_frame.promoted_switch_id = tx1[`SWL_F_PROMSID];
            next_f_frame.direct_dest_switch_id = tx2[`SWL_W_SID];
            next_f_frame.direct_dest_node_id = tx2[`SWL_W_LNID];
            next_f_frame.direct_dest_conn_id = tx2[`SWL_W_LCID];
            next_f_frame.direct_dest_no_aggr = tx2[`SWL_W_TOP];
          end
          // a frame arriving now still lands after this release
          if (w_strb[0] && w_data[`SWL_CMD_RXREL] && rx_full) begin
            next_rx_full = 1'b0;
          end
        end
        default: rsp = `SWL_RESP_SLVERR;
      endcase
      next_bresp = rsp;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    // read channel: one outstanding, data in the same cycle as arready
    if (arvalid && !arready && !rvalid) begin
      next_arready = 1'b1;
      next_rvalid = 1'b1;
      next_rresp = `SWL_RESP_OKAY;
      next_rdata = '0;
      case (araddr)
        `SWL_REG_TX0: next_rdata = tx0;
        `SWL_REG_TX1: next_rdata = tx1;
        `SWL_REG_TX2: next_rdata = tx2;
        `SWL_REG_CMD: next_rdata = '0;
        `SWL_REG_STATUS: begin
          next_rdata[`SWL_ST_TXBUSY] = f_valid;
          next_rdata[`SWL_ST_RXFULL] = rx_full;
        end
        `SWL_REG_RX0: next_rdata = rx0;
        `SWL_REG_RX1: next_rdata = rx1;
        `SWL_REG_RX2: next_rdata = rx2;
        default: next_rresp = `SWL_RESP_SLVERR;
      endcase
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx0 <= '0;
      tx1 <= '0;
      tx2 <= '0;
      rx0 <= '0;
      rx1 <= '0;
      rx2 <= '0;
      rx_full <= 1'b0;
      f_valid <= 1'b0;
      f_frame <= '0;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `SWL_RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= `SWL_RESP_OKAY;
      rdata <= '0;
    end else begin
      tx0 <= next_tx0;
      tx1 <= next_tx1;
      tx2 <= next_tx2;
      rx0 <= next_rx0;
      rx1 <= next_rx1;
      rx2 <= next_rx2;
      rx_full <= next_rx_full;
      f_valid <= next_f_valid;
      f_frame <= next_f_frame;
      aw_have <= next_aw_have;
      w_have <= next_w_have;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  assign lnk.f_valid = f_valid;
  assign lnk.f_frame = f_frame;
  assign lnk.r_ready = ~rx_full;
endmodule

/* bench/swl_link_properties.sv */
// link timing and forwarding properties of the switch end
`timescale 1ns/1ps
module swl_link_props (
  // clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // link signals
  input wire logic                f_valid,
  input wire logic                f_ready,
  input wire swl_pkg::swl_frame_t f_frame,
  input wire logic                r_valid,
  input wire logic                r_ready,
  input wire swl_pkg::swl_frame_t r_frame,
  input wire logic                r_aggr_ok,
  // switch settings
  input wire logic [7:0]          own_sid,
  input wire logic                uplink_aggr_cap
);
  import swl_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire take = f_valid && f_ready;

  property p_answer; take |=> r_valid && !f_ready; endproperty
  a_answer: assert property (p_answer)
    else $error("no answer after take");
  property p_hold;
    r_valid && !r_ready |=> r_valid && $stable(r_frame) && $stable(r_aggr_ok);
  endproperty
  a_hold: assert property (p_hold)
    else $error("answer dropped or changed");
  property p_release; r_valid && r_ready |=> !r_valid && f_ready; endproperty
  a_release: assert property (p_release)
    else $error("answer not released");
  property p_idle; !r_valid && !take |=> !r_valid; endproperty
  a_idle: assert property (p_idle)
    else $error("answer without take");
  property p_ctrl;
    take && f_frame.is_conn_ctrl |=> r_frame == $past(f_frame);
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("control frame altered");
  property p_down;
    take && f_frame.direction_bit |=> r_frame == $past(f_frame);
  endproperty
  a_down: assert property (p_down)
    else $error("downlink frame altered");
  property p_up;
    take && !f_frame.direction_bit
      |=> r_frame.direction_bit || r_frame == $past(f_frame);
  endproperty
  a_up: assert property (p_up)
    else $error("uplink frame altered without downlink turn");
  property p_last;
    r_valid && r_frame.direction_bit && r_frame.packet_switch_id == own_sid
      |-> r_aggr_ok == !r_frame.no_aggregation_flag;
  endproperty
  a_last: assert property (p_last)
    else $error("last level aggregation wrong");
  property p_up_aggr;
    r_valid && !r_frame.direction_bit |-> r_aggr_ok == uplink_aggr_cap;
  endproperty
  a_up_aggr: assert property (p_up_aggr)
    else $error("uplink aggregation wrong");
endmodule

/* bench/direct_switch_and_aggregation_tb_top.sv */
// bench joining switch and controller, driven over AXI4-Lite
`timescale 1ns/1ps
module direct_switch_and_aggregation_tb_top;
  logic        aclk = 0, aresetn = 0, uplink_aggr_cap = 1;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0, own_sid = 8'h05;
  logic [31:0] wdata = 0, rdata, q0, q1;
  logic [3:0]  wstrb = 4'hF;
  logic        awready, wready, bvalid, arready, rvalid, table_full;
  logic [1:0]  bresp, rresp, qr, qb;
  logic [15:0] aggr_size_limit;
  int          fail_count = 0, n_tests = 0, cyc = 0;
  // tx0, tx1, tx2, expected rx0, expected rx1 low bits
  logic [31:0] tab [17][5] = '{
    '{32'h04000105, 32'h0, 32'h0, 32'h04000105, 32'h40},
    '{32'h84000105, 32'h516, 32'h88000205, 32'h84000105, 32'h56},
    '{32'h04000105, 32'h0, 32'h0, 32'h88000205, 32'h01},
    '{32'h84400305, 32'h716, 32'h88000205, 32'h84400305, 32'h56},
    '{32'h04400305, 32'h0, 32'h0, 32'h04400305, 32'h40},
    '{32'h84000105, 32'h51E, 32'h08000205, 32'h84000105, 32'h5E},
    '{32'h04000105, 32'h0, 32'h0, 32'h88000205, 32'h01},
    '{32'h84000105, 32'h51E, 32'h88000205, 32'h84000105, 32'h5E},
    '{32'h04000105, 32'h0, 32'h0, 32'h04000105, 32'h40},
    '{32'h80000905, 32'h000A0020, 32'h0, 32'h80000905, 32'h60},
    '{32'h8000090A, 32'h0, 32'h0, 32'h8000090A, 32'h40},
    '{32'h8000090A, 32'h000B0021, 32'h0, 32'h8000090A, 32'h61},
    '{32'h8000090B, 32'h0, 32'h0, 32'h8000090B, 32'h40},
    '{32'h80000905, 32'h000C0021, 32'h0, 32'h80000905, 32'h21},
    '{32'h8000090C, 32'h0, 32'h0, 32'h8000090C, 32'h00},
    '{32'h8000090D, 32'h0, 32'h0, 32'h8000090D, 32'h00},
    '{32'h80000905, 32'h1, 32'h0, 32'h80000905, 32'h01}};

  swl_if lnk ();
  swl_switch #(.DEPTH(2)) swl_switch_i (.aclk(aclk), .aresetn(aresetn),
    .own_sid(own_sid), .uplink_aggr_cap(uplink_aggr_cap), .lnk(lnk),
    .table_full(table_full), .aggr_size_limit(aggr_size_limit));
  swl_root swl_root_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .lnk(lnk));
  swl_link_props swl_link_props_i (.aclk(aclk), .aresetn(aresetn),
    .f_valid(lnk.f_valid), .f_ready(lnk.f_ready), .f_frame(lnk.f_frame),
    .r_valid(lnk.r_valid), .r_ready(lnk.r_ready), .r_frame(lnk.r_frame),
    .r_aggr_ok(lnk.r_aggr_ok), .own_sid(own_sid),
    .uplink_aggr_cap(uplink_aggr_cap));

  always #5 aclk = ~aclk;

  task close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard, far above the roughly eight hundred cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      $display("[ERR] cycle limit expected end seen hang");
      close_out();
    end
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic a_ok, w_ok;
    a_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    awvalid <= 1; awaddr <= a; wvalid <= 1; wdata <= d; bready <= 1;
    while (!(a_ok && w_ok)) begin
      @(posedge aclk);
      if (awready) begin a_ok = 1; awvalid <= 0; end
      if (wready) begin w_ok = 1; wvalid <= 0; end
    end
    while (!bvalid) @(posedge aclk);
    qb = bresp;
    bready <= 0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    arvalid <= 1; araddr <= a; rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask

  // one frame through the switch: compose, send, collect, release
  task xfer(input logic [31:0] t0, input logic [31:0] t1,
            input logic [31:0] t2);
    wr(8'h00, t0); wr(8'h04, t1); wr(8'h08, t2); wr(8'h0C, 32'h1);
    q0 = 0;
    for (int k = 0; k < 50 && !q0[1]; k++) rd(8'h10, q0, qr);
    rd(8'h14, q0, qr);
    rd(8'h18, q1, qr);
    wr(8'h0C, 32'h2);
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 17; i++) begin
      xfer(tab[i][0], tab[i][1], tab[i][2]);
      chk("rx0", q0, tab[i][3]);
      chk("rx1", q1 & 32'h7F, tab[i][4]);
      $display("row %0d done", i);
    end
    chk("bresp", {30'h0, qb}, 32'h0);
    uplink_aggr_cap <= 0;
    xfer(32'h04000105, 32'h0, 32'h0);
    chk("up aggr", q1 & 32'h7F, 32'h0);
    uplink_aggr_cap <= 1;
    chk("limit", {16'h0, aggr_size_limit}, 32'h48);
    rd(8'h40, q0, qr);
    chk("unmapped", {30'h0, qr}, 32'h2);
    wr(8'h40, 32'h0);
    chk("wr unmapped", {30'h0, qb}, 32'h2);
    $display("capability and unmapped done");
    // two-entry table: third install must be dropped
    xfer(32'h84000105, 32'h516, 32'h88000205);
    xfer(32'h84400305, 32'h516, 32'h88000205);
    chk("full", {31'h0, table_full}, 32'h1);
    xfer(32'h84800405, 32'h516, 32'h88000205);
    xfer(32'h04800405, 32'h0, 32'h0);
    chk("drop", q0, 32'h04800405);
    xfer(32'h04400305, 32'h0, 32'h0);
    chk("hit", q0, 32'h88000205);
    $display("table full done");
    aresetn <= 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk("full rst", {31'h0, table_full}, 32'h0);
    xfer(32'h04000105, 32'h0, 32'h0);
    chk("rst miss", q0, 32'h04000105);
    $display("reset done");
    // second frame must wait in the switch while the rx slot is full
    wr(8'h00, 32'h04000105); wr(8'h04, 32'h0); wr(8'h08, 32'h0);
    wr(8'h0C, 32'h1);
    wr(8'h00, 32'h04400305);
    wr(8'h0C, 32'h1);
    repeat (3) @(posedge aclk);
    rd(8'h14, q0, qr);
    chk("held", q0, 32'h04000105);
    wr(8'h0C, 32'h2);
    q0 = 0;
    for (int k = 0; k < 50 && !q0[1]; k++) rd(8'h10, q0, qr);
    rd(8'h14, q0, qr);
    chk("waited", q0, 32'h04400305);
    $display("held frame done");
    close_out();
  end
endmodule
